// ==== src/sfd_pkg.sv ====
package sfd_pkg;
    localparam int SFD_NUM_CH = 2;
    localparam int SFD_SP_W = 11;
    // Overcurrent filter: persistence window lies in 20..40 cycles
    localparam int SFD_OC_FILT_CYC = 24;
    localparam int SFD_OC_CNT_W = 6;
    // On-state open-load/bypass delay in system clock cycles
    localparam int SFD_OPEN_LOAD_BYPASS_DLY_CYC = 8192;
    localparam int SFD_OPEN_LOAD_BYPASS_CNT_W = 14;
    // Power-up hold of the alert output before ready
    localparam int SFD_PWRUP_CYC = 16;
    localparam int SFD_PWRUP_CNT_W = 5;
    localparam logic SFD_ALERT_RST = 1'b0;
    localparam logic [1:0] SFD_SYNC_RST = 2'h0;
    // Off-state diagnostic current select codes
    localparam logic SFD_DIAG_PULL_UP = 1'b0;
    localparam logic SFD_DIAG_PULL_DN = 1'b1;
    localparam logic SFD_CFG_HIGH_SIDE = 1'b1;
endpackage

// ==== src/sfd_fault_diag.sv ====
`timescale 1ns/1ps
// Function
// - Overcurrent must persist filter interval before fault
// - Lower limit excess starts overcurrent filter counter
// - Upper limit is separate quick shutoff threshold
// - Quick shutoff disables stage immediately
// - Off state detects open load, not opposite short
// - Any unmasked fault drives alert low
// - Masked fault never affects alert
// - Alert low during power-up, released when ready
// - Enable pin mask gates enable pin onto alert
// - Channel mask gates channel flags onto alert
// - Overcurrent checked only enabled with nonzero setpoint
// - Overcurrent clears enable, setpoint, sets flag
// - Diagnosis read clears latched overcurrent flag
// - Restart needs read, then enable and setpoint
// - Low current beyond delay sets flag, disables
// - On-state open-load delay is 8192 cycles
// - Open-load flag latched, read clears if gone; the trip disables the channel, which marks it gone, so reads clear it anyway
// - One shared flag plus separate off-state flag
// - Bypass means battery short HS, ground short LS
// - Select field picks pull-up or pull-down
// - Diag current on when enabled with zero setpoint
// - Off flag from terminal versus half supply
// - Off-state flag never latched, follows live
module sfd_fault_diag
    import sfd_pkg::*;
#(
    parameter int NUM_CH = SFD_NUM_CH,
    parameter int SP_W = SFD_SP_W,
    parameter int OPEN_LOAD_BYPASS_DLY = SFD_OPEN_LOAD_BYPASS_DLY_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Host writes of enable and setpoint, one strobe per channel
    input wire logic [NUM_CH-1:0] i_ctrl_wr,
    input wire logic [NUM_CH-1:0] i_ctrl_en,
    input wire logic [NUM_CH*SP_W-1:0] i_ctrl_setpoint,
    input wire logic i_diag_rd,
    input wire logic [NUM_CH-1:0] i_high_side_cfg,
    input wire logic [NUM_CH-1:0] i_off_diag_current_select,
    input wire logic i_enable_pin_alert_mask,
    input wire logic [NUM_CH-1:0] i_channel_alert_mask,
    // Asynchronous comparator outputs
    input wire logic [NUM_CH-1:0] i_cur_above_lim_low,
    input wire logic [NUM_CH-1:0] i_cur_above_lim_high,
    input wire logic [NUM_CH-1:0] i_cur_below_open_load_bypass,
    input wire logic [NUM_CH-1:0] i_output_terminal_above_half,
    // Fault sources handled elsewhere, already synchronous
    input wire logic [NUM_CH-1:0] i_over_temp_flag,
    input wire logic [NUM_CH-1:0] i_under_voltage_flag,
    input wire logic i_enable_pin,
    input wire logic i_external_reset_low,
    input wire logic i_vdd_reset,
    input wire logic i_clock_fault,
    input wire logic i_bat_over_voltage,
    input wire logic i_watchdog_event,
    output logic [NUM_CH-1:0] o_ch_enable,
    output logic [NUM_CH*SP_W-1:0] o_ch_setpoint,
    output logic [NUM_CH-1:0] o_stage_on,
    output logic [NUM_CH-1:0] o_overcurrent_flag,
    output logic [NUM_CH-1:0] o_open_load_bypass_flag,
    output logic [NUM_CH-1:0] o_off_state_open_flag,
    output logic [NUM_CH-1:0] o_diag_pull_up_on,
    output logic [NUM_CH-1:0] o_diag_pull_dn_on,
    output logic o_fault_alert_low
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [NUM_CH-1:0] lo_s1;
        logic [NUM_CH-1:0] lo_s2;
        logic [NUM_CH-1:0] hi_s1;
        logic [NUM_CH-1:0] hi_s2;
        logic [NUM_CH-1:0] ol_s1;
        logic [NUM_CH-1:0] ol_s2;
        logic [NUM_CH-1:0] ot_s1;
        logic [NUM_CH-1:0] ot_s2;
        logic [NUM_CH-1:0] en;
        logic [NUM_CH*SP_W-1:0] sp;
        logic [NUM_CH-1:0] stage_on;
        logic [NUM_CH*SFD_OC_CNT_W-1:0] oc_cnt;
        logic [NUM_CH*SFD_OPEN_LOAD_BYPASS_CNT_W-1:0] ol_cnt;
        logic [NUM_CH-1:0] ovc;
        logic [NUM_CH-1:0] open_load_bypass;
        logic [NUM_CH-1:0] open_load_bypass_live;
        logic [NUM_CH-1:0] off_state_open_flag;
        logic [NUM_CH-1:0] pu_on, pd_on;
        logic [SFD_PWRUP_CNT_W-1:0] pwr_cnt;
        logic ready;
        logic alert_low;
    } sfd_state_t;

    sfd_state_t state_reg;
    sfd_state_t state_next;

    // Counters start at zero, so each limit is one below its cycle count
    localparam logic [SFD_OC_CNT_W-1:0] OC_LIMIT = SFD_OC_CNT_W'(SFD_OC_FILT_CYC - 1);
    localparam logic [SFD_OPEN_LOAD_BYPASS_CNT_W-1:0] OL_LIMIT = SFD_OPEN_LOAD_BYPASS_CNT_W'(OPEN_LOAD_BYPASS_DLY - 1);
    localparam logic [SFD_PWRUP_CNT_W-1:0] PWR_LIMIT = SFD_PWRUP_CNT_W'(SFD_PWRUP_CYC - 1);

    function automatic logic sp_nonzero(input logic [NUM_CH*SP_W-1:0] sp, input int ch);
        sp_nonzero = |sp[ch*SP_W +: SP_W];
    endfunction

    // Channel commanded on: enabled with a nonzero setpoint
    function automatic logic ch_run(
        input logic [NUM_CH-1:0] en,
        input logic [NUM_CH*SP_W-1:0] sp,
        input int ch
    );
        ch_run = en[ch] && sp_nonzero(sp, ch);
    endfunction

    // Parked for off-state diagnosis: enabled, setpoint zero
    function automatic logic ch_parked(
        input logic [NUM_CH-1:0] en,
        input logic [NUM_CH*SP_W-1:0] sp,
        input int ch
    );
        ch_parked = en[ch] && !sp_nonzero(sp, ch);
    endfunction

    function automatic logic [SFD_OC_CNT_W-1:0] oc_of(
        input logic [NUM_CH*SFD_OC_CNT_W-1:0] cnt,
        input int ch
    );
        oc_of = cnt[ch*SFD_OC_CNT_W +: SFD_OC_CNT_W];
    endfunction

    function automatic logic [SFD_OPEN_LOAD_BYPASS_CNT_W-1:0] ol_of(
        input logic [NUM_CH*SFD_OPEN_LOAD_BYPASS_CNT_W-1:0] cnt,
        input int ch
    );
        ol_of = cnt[ch*SFD_OPEN_LOAD_BYPASS_CNT_W +: SFD_OPEN_LOAD_BYPASS_CNT_W];
    endfunction

    // Both latched faults drop control and stage in the same cycle
    function automatic sfd_state_t shut_ch(
        input sfd_state_t s,
        input int ch
    );
        shut_ch = s;
        shut_ch.en[ch] = 1'b0;
        shut_ch.sp[ch*SP_W +: SP_W] = '0;
        shut_ch.stage_on[ch] = 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; async assert, sync deassert
    logic [1:0] rst_pipe_reg;
    logic rst_b_int;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pipe_reg <= SFD_SYNC_RST;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    // Everything below resets from the released copy only
    assign rst_b_int = rst_pipe_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    logic [SFD_OC_CNT_W-1:0] oc_c;
    logic [SFD_OPEN_LOAD_BYPASS_CNT_W-1:0] ol_c;
    logic active;
    logic ch_fault;
    logic any_fault;
    // Per-channel scratch, rewritten on every loop pass; glob_fault is device-wide, set once after the loop
    logic trip_oc;
    logic trip_ol;
    logic parked;
    logic glob_fault;

    always_comb begin
        state_next = state_reg;
        oc_c = '0;
        ol_c = '0;
        active = 1'b0;
        ch_fault = 1'b0;
        any_fault = 1'b0;
        trip_oc = 1'b0;
        trip_ol = 1'b0;
        parked = 1'b0;
        glob_fault = 1'b0;

        // Second stage alone feeds the logic
        // Lower limit comparator
        state_next.lo_s1 = i_cur_above_lim_low;
        state_next.lo_s2 = state_reg.lo_s1;

        // Quick shutoff comparator
        state_next.hi_s1 = i_cur_above_lim_high;
        state_next.hi_s2 = state_reg.hi_s1;

        // Low-current comparator
        state_next.ol_s1 = i_cur_below_open_load_bypass;
        state_next.ol_s2 = state_reg.ol_s1;

        // Terminal versus half supply
        state_next.ot_s1 = i_output_terminal_above_half;
        state_next.ot_s2 = state_reg.ot_s1;

        // Read clears flags; fresh events below take priority
        if (i_diag_rd) begin
            state_next.ovc = '0;
            state_next.open_load_bypass = state_reg.open_load_bypass & state_reg.open_load_bypass_live;
        end

        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (i_ctrl_wr[ch]) begin
                state_next.en[ch] = i_ctrl_en[ch];
                state_next.sp[ch*SP_W +: SP_W] = i_ctrl_setpoint[ch*SP_W +: SP_W];
            end

            active = ch_run(state_reg.en, state_reg.sp, ch);
            parked = ch_parked(state_reg.en, state_reg.sp, ch);
            oc_c = oc_of(state_reg.oc_cnt, ch);
            ol_c = ol_of(state_reg.ol_cnt, ch);

            // A latched flag blocks restart until the host has read it
            state_next.stage_on[ch] = active && !state_reg.ovc[ch] && !state_reg.open_load_bypass[ch];

            // Quick shutoff needs no persistence
            trip_oc = state_reg.hi_s2[ch];
            // Lower limit must persist through the whole window
            trip_oc = trip_oc || (state_reg.lo_s2[ch] && oc_c >= OC_LIMIT);
            // Low current must outlast the on-state delay
            trip_ol = state_reg.ol_s2[ch] && ol_c >= OL_LIMIT;

            if (active && state_reg.stage_on[ch]) begin
                // Lower limit excess runs the filter count
                if (state_reg.lo_s2[ch]) begin
                    state_next.oc_cnt[ch*SFD_OC_CNT_W +: SFD_OC_CNT_W] = oc_c + 1'b1;
                end else begin
                    state_next.oc_cnt[ch*SFD_OC_CNT_W +: SFD_OC_CNT_W] = '0;
                end
                if (trip_oc) begin
                    state_next = shut_ch(state_next, ch);
                    state_next.ovc[ch] = 1'b1;
                    state_next.oc_cnt[ch*SFD_OC_CNT_W +: SFD_OC_CNT_W] = '0;
                end

                // On-state open load or bypass
                if (state_reg.ol_s2[ch]) begin
                    state_next.ol_cnt[ch*SFD_OPEN_LOAD_BYPASS_CNT_W +: SFD_OPEN_LOAD_BYPASS_CNT_W] = ol_c + 1'b1;
                end else begin
                    state_next.ol_cnt[ch*SFD_OPEN_LOAD_BYPASS_CNT_W +: SFD_OPEN_LOAD_BYPASS_CNT_W] = '0;
                    state_next.open_load_bypass_live[ch] = 1'b0;
                end
                if (trip_ol) begin
                    state_next = shut_ch(state_next, ch);
                    state_next.open_load_bypass[ch] = 1'b1;
                    state_next.open_load_bypass_live[ch] = 1'b1;
                    state_next.ol_cnt[ch*SFD_OPEN_LOAD_BYPASS_CNT_W +: SFD_OPEN_LOAD_BYPASS_CNT_W] = '0;
                end
            end else begin
                // Counters restart whenever the stage is not driving
                state_next.oc_cnt[ch*SFD_OC_CNT_W +: SFD_OC_CNT_W] = '0;
                state_next.ol_cnt[ch*SFD_OPEN_LOAD_BYPASS_CNT_W +: SFD_OPEN_LOAD_BYPASS_CNT_W] = '0;
                // Condition judged gone once the channel is disabled
                if (!state_reg.en[ch]) begin
                    state_next.open_load_bypass_live[ch] = 1'b0;
                end
            end

            // Off-state source: enabled with zero setpoint only
            state_next.pu_on[ch] = parked
                && (i_off_diag_current_select[ch] == SFD_DIAG_PULL_UP);
            state_next.pd_on[ch] = parked
                && (i_off_diag_current_select[ch] == SFD_DIAG_PULL_DN);

            // Live flag versus half supply; pull-up reads low when loaded,
            // pull-down reads high when bypassed. Only an open or the
            // short the source can see is reported.
            if (state_reg.pu_on[ch]) begin
                state_next.off_state_open_flag[ch] = state_reg.ot_s2[ch];
            end else if (state_reg.pd_on[ch]) begin
                state_next.off_state_open_flag[ch] = !state_reg.ot_s2[ch];
            end else begin
                state_next.off_state_open_flag[ch] = 1'b0;
            end

            // Channel sources count only where that channel's mask admits them
            ch_fault = state_reg.ovc[ch];
            ch_fault = ch_fault | state_reg.open_load_bypass[ch];
            ch_fault = ch_fault | i_over_temp_flag[ch];
            ch_fault = ch_fault | i_under_voltage_flag[ch];
            any_fault = any_fault | (i_channel_alert_mask[ch] & ch_fault);
        end

        // Device-wide sources bypass the channel masks
        glob_fault = !i_external_reset_low;
        glob_fault = glob_fault | i_vdd_reset;
        glob_fault = glob_fault | i_clock_fault;
        glob_fault = glob_fault | i_bat_over_voltage;
        glob_fault = glob_fault | i_watchdog_event;
        // Enable pin counts only when its mask admits it
        any_fault = any_fault | (i_enable_pin_alert_mask & !i_enable_pin);
        any_fault = any_fault | glob_fault;

        // Power-up hold before ready
        if (!state_reg.ready) begin
            state_next.pwr_cnt = state_reg.pwr_cnt + 1'b1;
            state_next.ready = (state_reg.pwr_cnt == PWR_LIMIT);
        end
        // Field holds the pin level, so reset and power-up keep it low
        state_next.alert_low = state_reg.ready && !any_fault;
    end

    always_ff @(posedge i_ref_clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control state as seen by the power stage
    assign o_ch_enable = state_reg.en;
    assign o_ch_setpoint = state_reg.sp;
    assign o_stage_on = state_reg.stage_on;

    // Latched and live flags
    assign o_overcurrent_flag = state_reg.ovc;
    assign o_open_load_bypass_flag = state_reg.open_load_bypass;
    assign o_off_state_open_flag = state_reg.off_state_open_flag;

    // Off-state diagnostic sources
    assign o_diag_pull_up_on = state_reg.pu_on;
    assign o_diag_pull_dn_on = state_reg.pd_on;
    // Straight from its flop: a cleared struct means the alert is asserted
    assign o_fault_alert_low = state_reg.alert_low;

endmodule

// ==== bench/sfd_fault_diag_asserts.sv ====
`timescale 1ns/1ps
module sfd_fault_diag_asserts
    import sfd_pkg::*;
#(
    parameter int NUM_CH = SFD_NUM_CH,
    parameter int SP_W = SFD_SP_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_diag_rd,
    input wire logic [NUM_CH-1:0] i_cur_above_lim_low,
    input wire logic [NUM_CH-1:0] i_cur_above_lim_high,
    input wire logic [NUM_CH-1:0] i_channel_alert_mask,
    input wire logic [NUM_CH-1:0] o_ch_enable,
    input wire logic [NUM_CH*SP_W-1:0] o_ch_setpoint,
    input wire logic [NUM_CH-1:0] o_stage_on,
    input wire logic [NUM_CH-1:0] o_overcurrent_flag,
    input wire logic [NUM_CH-1:0] o_open_load_bypass_flag,
    input wire logic [NUM_CH-1:0] o_diag_pull_up_on,
    input wire logic [NUM_CH-1:0] o_diag_pull_dn_on,
    input wire logic o_fault_alert_low
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Channel 0 only; the bench covers channel 1
    logic run0;
    assign run0 = o_ch_enable[0] && (o_ch_setpoint[SP_W-1:0] != '0);
    sequence s_oc_armed;
        $rose(i_cur_above_lim_low[0]) && !i_cur_above_lim_high[0] && run0 && !o_overcurrent_flag[0];
    endsequence
    property p_oc_min; s_oc_armed |-> ##19 !o_overcurrent_flag[0]; endproperty
    a_oc_min: assert property (p_oc_min) else $error("overcurrent flagged too early");
    property p_oc_max; s_oc_armed |-> ##[20:44] o_overcurrent_flag[0]; endproperty
    a_oc_max: assert property (p_oc_max) else $error("persistent overcurrent not flagged");
    property p_quick;
        $rose(i_cur_above_lim_high[0]) && run0 |-> ##[1:4] (o_overcurrent_flag[0] && !o_stage_on[0]);
    endproperty
    a_quick: assert property (p_quick) else $error("quick shutoff too slow");
    property p_oc_cause;
        $rose(o_overcurrent_flag[0]) |-> $past(run0) && !o_ch_enable[0] && o_ch_setpoint[SP_W-1:0] == '0;
    endproperty
    a_oc_cause: assert property (p_oc_cause) else $error("overcurrent flag without clearing control");
    property p_rd_clear; i_diag_rd && !o_ch_enable[0] |=> !o_overcurrent_flag[0]; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read left overcurrent flag set");
    property p_refuse; o_overcurrent_flag[0] || o_open_load_bypass_flag[0] |=> !o_stage_on[0]; endproperty
    a_refuse: assert property (p_refuse) else $error("stage on while fault latched");
    property p_alert;
        (o_overcurrent_flag[0] && i_channel_alert_mask[0]) ##1 i_channel_alert_mask[0] |-> !o_fault_alert_low;
    endproperty
    a_alert: assert property (p_alert) else $error("unmasked fault left alert high");
    property p_pwrup; $rose(i_rst_b) |-> !o_fault_alert_low [*8]; endproperty
    a_pwrup: assert property (p_pwrup) else $error("alert released during power-up");
    property p_diag_off; !o_ch_enable[0] [*2] |-> !o_diag_pull_up_on[0] && !o_diag_pull_dn_on[0]; endproperty
    a_diag_off: assert property (p_diag_off) else $error("diagnostic current on while disabled");
endmodule

bind sfd_fault_diag sfd_fault_diag_asserts #(.NUM_CH(NUM_CH), .SP_W(SP_W)) u_sfd_fault_diag_asserts (.*);

// ==== bench/sfd_host_model.sv ====
`timescale 1ns/1ps
module sfd_host_model
    import sfd_pkg::*;
(
    input wire logic i_ref_clk,
    output logic [SFD_NUM_CH-1:0] o_ctrl_wr,
    output logic [SFD_NUM_CH-1:0] o_ctrl_en,
    output logic [SFD_NUM_CH*SFD_SP_W-1:0] o_ctrl_setpoint,
    output logic o_diag_rd,
    output logic [SFD_NUM_CH-1:0] o_diag_sel
);
    initial begin
        o_ctrl_wr = '0;
        o_ctrl_en = '0;
        o_ctrl_setpoint = '0;
        o_diag_rd = 1'b0;
        o_diag_sel = {SFD_NUM_CH{SFD_DIAG_PULL_UP}};
    end
    task automatic wr(input int ch, input logic en, input logic [SFD_SP_W-1:0] sp);
        @(negedge i_ref_clk);
        o_ctrl_wr[ch] = 1'b1;
        o_ctrl_en[ch] = en;
        o_ctrl_setpoint[ch*SFD_SP_W +: SFD_SP_W] = sp;
        @(negedge i_ref_clk);
        o_ctrl_wr = '0;
    endtask
    task automatic rd();
        @(negedge i_ref_clk);
        o_diag_rd = 1'b1;
        @(negedge i_ref_clk);
        o_diag_rd = 1'b0;
    endtask
    // Flags must drop before the channel is armed again
    task automatic restart(input int ch, input logic [SFD_SP_W-1:0] sp);
        rd();
        wr(ch, 1'b1, sp);
    endtask
    // Weak sources charge the load slowly, so the flag is only valid after settling
    task automatic sel(input int ch, input logic s, input int settle);
        @(negedge i_ref_clk);
        o_diag_sel[ch] = s;
        repeat (settle) @(negedge i_ref_clk);
    endtask
endmodule

// ==== bench/sfd_fault_diag_tb.sv ====
`timescale 1ns/1ps
module sfd_fault_diag_tb;
    import sfd_pkg::*;
    localparam int DLY = 64;
    logic clk, rst_b, pm, alert_b, rd_s;
    logic [1:0] lo, hi, below, above, mask, wr_s, en_s, sel, en_o, stage, ovc, open_load_bypass, off_state_open_flag, up, dn;
    logic [21:0] sp_s, sp_o;
    logic [7:0] src;
    int err_total = 0, n_compared = 0, cyc = 0;
    sfd_host_model u_sfd_host_model (.i_ref_clk(clk), .o_ctrl_wr(wr_s), .o_ctrl_en(en_s),
        .o_ctrl_setpoint(sp_s), .o_diag_rd(rd_s), .o_diag_sel(sel));
    sfd_fault_diag #(.OPEN_LOAD_BYPASS_DLY(DLY)) u_sfd_fault_diag (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_ctrl_wr(wr_s), .i_ctrl_en(en_s), .i_ctrl_setpoint(sp_s), .i_diag_rd(rd_s),
        .i_high_side_cfg(2'h1), .i_off_diag_current_select(sel), .i_enable_pin_alert_mask(pm),
        .i_channel_alert_mask(mask), .i_cur_above_lim_low(lo), .i_cur_above_lim_high(hi),
        .i_cur_below_open_load_bypass(below), .i_output_terminal_above_half(above),
        .i_over_temp_flag({1'b0, src[6]}), .i_under_voltage_flag({src[7], 1'b0}),
        .i_enable_pin(!src[0]), .i_external_reset_low(!src[1]), .i_vdd_reset(src[2]),
        .i_clock_fault(src[3]), .i_bat_over_voltage(src[4]), .i_watchdog_event(src[5]),
        .o_ch_enable(en_o), .o_ch_setpoint(sp_o), .o_stage_on(stage), .o_overcurrent_flag(ovc),
        .o_open_load_bypass_flag(open_load_bypass), .o_off_state_open_flag(off_state_open_flag), .o_diag_pull_up_on(up),
        .o_diag_pull_dn_on(dn), .o_fault_alert_low(alert_b));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] v, input logic [31:0] e);
        n_compared++;
        if (v !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    task automatic t_quick();
        u_sfd_host_model.wr(0, 1'b1, 11'h064);
        w(3);
        lo[0] = 1'b1;
        hi[0] = 1'b1;
        w(6);
        chk({ovc, en_o, sp_o[10:0], stage, alert_b}, 17'h10000);
        lo = '0;
        hi = '0;
        u_sfd_host_model.wr(0, 1'b1, 11'h064);
        w(3);
        chk(stage, 2'h0);
        u_sfd_host_model.restart(0, 11'h064);
        w(3);
        chk({ovc, stage, alert_b}, 5'h03);
        $display("done quick shutoff");
    endtask
    task automatic t_filter();
        u_sfd_host_model.wr(0, 1'b0, 11'h064);
        lo[0] = 1'b1;
        w(50);
        chk(ovc, 2'h0);
        lo[0] = 1'b0;
        u_sfd_host_model.wr(0, 1'b1, 11'h064);
        w(3);
        lo[0] = 1'b1;
        w(18);
        chk(ovc, 2'h0);
        w(27);
        chk({ovc, en_o}, 4'h4);
        lo[0] = 1'b0;
        u_sfd_host_model.rd();
        $display("done overcurrent filter");
    endtask
    task automatic t_mask();
        mask = 2'h1;
        u_sfd_host_model.wr(1, 1'b1, 11'h7FF);
        w(3);
        hi[1] = 1'b1;
        w(8);
        chk({ovc, alert_b}, 3'h5);
        hi[1] = 1'b0;
        mask = 2'h3;
        w(3);
        chk(alert_b, 1'b0);
        u_sfd_host_model.rd();
        w(3);
        chk(alert_b, 1'b1);
        for (int i = 0; i < 8; i++) begin
            src = 8'h01 << i;
            w(3);
            chk(alert_b, 1'b0);
            src = '0;
            w(3);
            chk(alert_b, 1'b1);
        end
        mask = 2'h2;
        pm = 1'b0;
        src = 8'h41;
        w(3);
        chk(alert_b, 1'b1);
        src = '0;
        mask = 2'h3;
        pm = 1'b1;
        $display("done alert masks");
    endtask
    task automatic t_open_load_bypass();
        u_sfd_host_model.restart(0, 11'h001);
        w(3);
        chk(stage, 2'h1);
        below[0] = 1'b1;
        w(DLY - 4);
        chk(open_load_bypass, 2'h0);
        w(12);
        chk({open_load_bypass, en_o, stage, alert_b}, 7'h20);
        u_sfd_host_model.rd();
        chk(open_load_bypass, 2'h0);
        below[0] = 1'b0;
        $display("done open load on");
    endtask
    task automatic t_off();
        u_sfd_host_model.wr(0, 1'b1, 11'h000);
        u_sfd_host_model.sel(0, SFD_DIAG_PULL_UP, 4);
        chk({up, dn, stage}, 6'h10);
        above[0] = 1'b1;
        w(4);
        chk({off_state_open_flag, open_load_bypass, ovc}, 6'h10);
        above[0] = 1'b0;
        w(4);
        chk(off_state_open_flag, 2'h0);
        u_sfd_host_model.sel(0, SFD_DIAG_PULL_DN, 4);
        chk({up, dn, off_state_open_flag}, 6'h05);
        u_sfd_host_model.wr(0, 1'b1, 11'h010);
        w(2);
        chk({up, dn}, 4'h0);
        $display("done off-state diagnosis");
    endtask
    initial begin
        rst_b = 1'b0;
        pm = 1'b1;
        mask = 2'h3;
        {lo, hi, below, above, src} = '0;
        w(20);
        rst_b = 1'b1;
        w(8);
        chk(alert_b, 1'b0);
        w(20);
        chk(alert_b, 1'b1);
        t_quick();
        t_filter();
        t_mask();
        t_open_load_bypass();
        t_off();
        conclude();
    end
endmodule
